//--- twm_pkg.sv
package twm_pkg;

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] TWM_CTRL_OFF   = 8'h00;
  localparam logic [7:0] TWM_MODE_OFF   = 8'h04;
  localparam logic [7:0] TWM_CLKDIV_OFF = 8'h10;
  localparam logic [7:0] TWM_STAT_OFF   = 8'h20;
  localparam logic [7:0] TWM_RHR_OFF    = 8'h30;
  localparam logic [7:0] TWM_THR_OFF    = 8'h34;

  // ==========================================================================
  // Field positions.
  localparam int TWM_CR_START     = 0;
  localparam int TWM_CR_MSEN      = 2;
  localparam int TWM_CR_MASTER_DISABLE_BIT     = 3;
  localparam int TWM_CR_SWRST     = 7;
  localparam int TWM_MODE_READ    = 12;
  localparam int TWM_MODE_ADDR    = 16;
  localparam int TWM_DIV_LOW      = 0;
  localparam int TWM_DIV_HIGH     = 8;
  localparam int TWM_DIV_EXP      = 16;
  localparam int TWM_SR_TRANSFER_COMPLETE_FLAG    = 0;
  localparam int TWM_SR_RECEIVE_READY_FLAG     = 1;
  localparam int TWM_SR_TRANSMIT_READY_FLAG     = 2;
  localparam int TWM_SR_OVRE      = 6;
  localparam int TWM_SR_NOT_ACKNOWLEDGED_FLAG      = 8;
  localparam int TWM_SR_STUCK     = 15;

  // ==========================================================================
  // Bus answers and fixed values.
  localparam logic [1:0] TWM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TWM_RESP_SLVERR = 2'h2;
  localparam logic [7:0] TWM_RX_FILL     = 8'hff;
  localparam logic [3:0] TWM_ACK_BIT     = 4'h8;

  typedef enum logic [1:0] {TWM_IDLE, TWM_START, TWM_BIT, TWM_STOP} twm_st_t;

  typedef struct packed {
    twm_st_t     st;
    logic        msen;
    logic        stuck;
    logic        phase_hi;
    logic [13:0] cnt;
    logic [3:0]  bit_idx;
    logic        byte_sel;
    logic        not_acknowledged_flag_pend;
    logic [7:0]  sh;
    logic [7:0]  thr;
    logic [7:0]  receive_holding_reg;
    logic        rd_dir;
    logic [6:0]  saddr;
    logic [7:0]  low_phase_divider;
    logic [7:0]  high_phase_divider;
    logic [2:0]  divider_exponent;
    logic        transfer_complete_flag;
    logic        transmit_ready_flag;
    logic        receive_ready_flag;
    logic        overrun_flag;
    logic        not_acknowledged_flag;
    logic        scl_oe;
    logic        sda_oe;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_f;
    logic        sda_f;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } twm_state_t;

  localparam twm_state_t TWM_STATE_RST = '{
    st: TWM_IDLE, transfer_complete_flag: 1'b1, transmit_ready_flag: 1'b1,
    scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1, default: '0};

endpackage : twm_pkg

//--- twm_master.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module twm_master
(
  // Clock, reset and clock enable.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite slave.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Open-drain serial pins.
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  import twm_pkg::*;

  twm_state_t  s_r;
  twm_state_t  s_nxt;
  logic        rd_sr;
  logic        byte_done;
  logic [13:0] low_c;
  logic [13:0] high_c;

  // ==========================================================================
  // Helpers.
  function automatic logic [13:0] phase_cycles(input logic [7:0] div, input logic [2:0] e);
    phase_cycles = (14'(div) << e) + 14'h1;
  endfunction : phase_cycles

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == TWM_CTRL_OFF) || (a == TWM_MODE_OFF) || (a == TWM_CLKDIV_OFF) ||
             (a == TWM_STAT_OFF) || (a == TWM_RHR_OFF) || (a == TWM_THR_OFF);
  endfunction : mapped

  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready  = !s_r.w_got && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = s_r.scl_oe;
  assign sda_oe  = s_r.sda_oe;
  assign low_c   = phase_cycles(s_r.low_phase_divider, s_r.divider_exponent);
  assign high_c  = phase_cycles(s_r.high_phase_divider, s_r.divider_exponent);
  assign rd_sr   = arvalid && arready && (araddr == TWM_STAT_OFF);

  // ==========================================================================
  // Next state.
  always_comb
  begin
    logic [31:0] wv;
    logic        wr_fire;
    logic        to_stop;
    wv        = '0;
    wr_fire   = s_r.aw_got && s_r.w_got;
    to_stop   = 1'b0;
    byte_done = 1'b0;
    s_nxt     = s_r;
    // Pins pass three stages; a new level counts once the last two agree.
    s_nxt.scl_sy = {s_r.scl_sy[1:0], scl_i};
    s_nxt.sda_sy = {s_r.sda_sy[1:0], sda_i};
    if (s_r.scl_sy[1] == s_r.scl_sy[2])
      s_nxt.scl_f = s_r.scl_sy[2];
    if (s_r.sda_sy[1] == s_r.sda_sy[2])
      s_nxt.sda_f = s_r.sda_sy[2];

    if (awvalid && awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;

    // Read side effects come first so that a flag set below in the same cycle wins.
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = mapped(araddr) ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
      s_nxt.rdata  = '0;
      case (araddr)
        TWM_MODE_OFF:
        begin
          s_nxt.rdata[TWM_MODE_READ]        = s_r.rd_dir;
          s_nxt.rdata[TWM_MODE_ADDR +: 7]   = s_r.saddr;
        end
        TWM_CLKDIV_OFF:
        begin
          s_nxt.rdata[TWM_DIV_LOW +: 8]  = s_r.low_phase_divider;
          s_nxt.rdata[TWM_DIV_HIGH +: 8] = s_r.high_phase_divider;
          s_nxt.rdata[TWM_DIV_EXP +: 3]  = s_r.divider_exponent;
        end
        TWM_STAT_OFF:
        begin
          s_nxt.rdata[TWM_SR_TRANSFER_COMPLETE_FLAG] = s_r.transfer_complete_flag;
          s_nxt.rdata[TWM_SR_RECEIVE_READY_FLAG]  = s_r.receive_ready_flag;
          s_nxt.rdata[TWM_SR_TRANSMIT_READY_FLAG]  = s_r.transmit_ready_flag;
          s_nxt.rdata[TWM_SR_OVRE]   = s_r.overrun_flag;
          s_nxt.rdata[TWM_SR_NOT_ACKNOWLEDGED_FLAG]   = s_r.not_acknowledged_flag;
          s_nxt.rdata[TWM_SR_STUCK]  = s_r.stuck;
          s_nxt.not_acknowledged_flag = 1'b0;
          s_nxt.not_acknowledged_flag_pend             = 1'b0;
        end
        TWM_RHR_OFF:
        begin
          s_nxt.rdata[7:0]        = s_r.receive_holding_reg;
          s_nxt.receive_ready_flag = 1'b0;
          s_nxt.overrun_flag       = 1'b0;
        end
        default:
          s_nxt.rdata = '0;
      endcase
    end

    if (wr_fire)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = mapped(s_r.awaddr) ? TWM_RESP_OKAY : TWM_RESP_SLVERR;
      case (s_r.awaddr)
        TWM_CTRL_OFF:
        begin
          wv = s_r.wstrb[0] ? s_r.wdata : '0;
          if (wv[TWM_CR_MASTER_DISABLE_BIT])
            s_nxt.msen = 1'b0;
          else if (wv[TWM_CR_MSEN])
            s_nxt.msen = 1'b1;
          if (wv[TWM_CR_SWRST])
          begin
            // The lock-up is kept until the system reset; software reset cannot lift it.
            // Our own pull counts as low at once; the synchronised level lags a few cycles.
            s_nxt.stuck = s_r.stuck ||
                          (s_r.st != TWM_IDLE && (s_r.scl_oe || !s_r.scl_f));
            s_nxt.st                     = TWM_IDLE;
            s_nxt.msen                   = 1'b0;
            s_nxt.scl_oe                 = 1'b0;
            s_nxt.sda_oe                 = 1'b0;
            s_nxt.transfer_complete_flag = 1'b1;
            s_nxt.transmit_ready_flag    = 1'b1;
            s_nxt.receive_ready_flag     = 1'b0;
            s_nxt.overrun_flag           = 1'b0;
            s_nxt.not_acknowledged_flag  = 1'b0;
            s_nxt.not_acknowledged_flag_pend              = 1'b0;
          end
          else if (wv[TWM_CR_START] && s_nxt.msen && s_r.st == TWM_IDLE && !s_r.stuck)
          begin
            s_nxt.st                     = TWM_START;
            s_nxt.transfer_complete_flag = 1'b0;
            s_nxt.sda_oe                 = 1'b1;
            s_nxt.cnt                    = high_c;
            s_nxt.byte_sel               = 1'b0;
            s_nxt.bit_idx                = '0;
            s_nxt.sh                     = {s_r.saddr, s_r.rd_dir};
          end
        end
        TWM_MODE_OFF:
        begin
          wv           = merge({9'h0, s_r.saddr, 3'h0, s_r.rd_dir, 12'h0},
                               s_r.wdata, s_r.wstrb);
          s_nxt.rd_dir = wv[TWM_MODE_READ];
          s_nxt.saddr  = wv[TWM_MODE_ADDR +: 7];
        end
        TWM_CLKDIV_OFF:
        begin
          wv = merge({13'h0, s_r.divider_exponent, s_r.high_phase_divider,
                      s_r.low_phase_divider}, s_r.wdata, s_r.wstrb);
          s_nxt.low_phase_divider  = wv[TWM_DIV_LOW +: 8];
          s_nxt.high_phase_divider = wv[TWM_DIV_HIGH +: 8];
          s_nxt.divider_exponent   = wv[TWM_DIV_EXP +: 3];
        end
        TWM_THR_OFF:
        begin
          if (s_r.wstrb[0] && s_r.msen)
          begin
            s_nxt.thr                 = s_r.wdata[7:0];
            s_nxt.transmit_ready_flag = 1'b0;
          end
        end
        default:
          wv = '0;
      endcase
    end

    // A disabled master does not step the engine; only a software reset or a register read changes its state, pins or flags.
    if (s_r.msen && s_nxt.msen)
    begin
      case (s_r.st)
        TWM_START:
        begin
          if (s_r.cnt == '0)
          begin
            s_nxt.st       = TWM_BIT;
            s_nxt.scl_oe   = 1'b1;
            s_nxt.phase_hi = 1'b0;
            s_nxt.cnt      = low_c;
          end
        end
        TWM_BIT:
        begin
          if (!s_r.phase_hi)
          begin
            // The acknowledge slot is always released: a read ends on a not-acknowledge.
            s_nxt.sda_oe = !s_r.bit_idx[3] && !s_r.sh[7];
            if (s_r.cnt == '0)
            begin
              s_nxt.scl_oe   = 1'b0;
              s_nxt.phase_hi = 1'b1;
              s_nxt.cnt      = high_c;
            end
          end
          else if (s_r.cnt == '0)
          begin
            s_nxt.scl_oe   = 1'b1;
            s_nxt.phase_hi = 1'b0;
            s_nxt.cnt      = low_c;
            if (s_r.bit_idx != TWM_ACK_BIT)
            begin
              s_nxt.sh      = {s_r.sh[6:0], s_r.sda_f};
              s_nxt.bit_idx = s_r.bit_idx + 4'h1;
            end
            else
            begin
              s_nxt.bit_idx = '0;
              if (!s_r.byte_sel)
              begin
                if (s_r.sda_f)
                begin
                  s_nxt.not_acknowledged_flag_pend = 1'b1;
                  to_stop         = 1'b1;
                end
                else
                begin
                  s_nxt.byte_sel            = 1'b1;
                  s_nxt.sh                  = s_r.rd_dir ? TWM_RX_FILL : s_r.thr;
                  s_nxt.transmit_ready_flag = 1'b1;
                end
              end
              else
              begin
                byte_done                 = 1'b1;
                s_nxt.receive_holding_reg = s_r.sh;
                if (s_r.rd_dir)
                begin
                  s_nxt.overrun_flag       = s_nxt.overrun_flag | s_nxt.receive_ready_flag;
                  s_nxt.receive_ready_flag = 1'b1;
                end
                else if (s_r.sda_f)
                  s_nxt.not_acknowledged_flag_pend = 1'b1;
                to_stop = 1'b1;
              end
            end
          end
        end
        TWM_STOP:
        begin
          if (!s_r.phase_hi)
          begin
            s_nxt.sda_oe = 1'b1;
            if (s_r.cnt == '0)
            begin
              s_nxt.scl_oe   = 1'b0;
              s_nxt.phase_hi = 1'b1;
              s_nxt.cnt      = high_c;
            end
          end
          else if (s_r.cnt == '0)
          begin
            s_nxt.sda_oe                 = 1'b0;
            s_nxt.st                     = TWM_IDLE;
            s_nxt.transfer_complete_flag = 1'b1;
            s_nxt.not_acknowledged_flag  = s_r.not_acknowledged_flag_pend;
            s_nxt.not_acknowledged_flag_pend              = 1'b0;
          end
        end
        default:
          s_nxt.cnt = s_r.cnt;
      endcase
      if (s_r.st != TWM_IDLE && s_r.cnt != '0)
        s_nxt.cnt = s_r.cnt - 14'h1;
      if (to_stop)
      begin
        s_nxt.st       = TWM_STOP;
        s_nxt.scl_oe   = 1'b1;
        s_nxt.phase_hi = 1'b0;
        s_nxt.cnt      = low_c;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_r <= TWM_STATE_RST;
    else if (ce)
      s_r <= s_nxt;
  end

  // ==========================================================================
  // Checks.
  chk_disable_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !s_r.msen && s_r.st != TWM_IDLE && !(s_r.aw_got && s_r.w_got)) |=>
      ($stable(s_r.st) && $stable(s_r.cnt) && $stable(scl_oe) && $stable(sda_oe)))
    else $error("engine moved while disabled");
  chk_flags_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_r.msen && !s_r.aw_got) |=>
      ($stable(s_r.transfer_complete_flag) && $stable(s_r.transmit_ready_flag)))
    else $error("flags changed while disabled");
  chk_not_acknowledged_flag_with_comp: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_r.not_acknowledged_flag) |-> $rose(s_r.transfer_complete_flag))
    else $error("not-acknowledged set apart from transfer complete");
  chk_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rd_sr && s_r.st != TWM_STOP) |=> !s_r.not_acknowledged_flag)
    else $error("status read left not-acknowledged set");
  chk_not_acknowledged_flag_lost: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rd_sr && s_r.st == TWM_STOP) |=> !s_r.not_acknowledged_flag_pend ##1 !$rose(s_r.not_acknowledged_flag))
    else $error("pending not-acknowledge survived a status read");
  chk_rhr_any_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && byte_done) |=> (s_r.receive_holding_reg == $past(s_r.sh)))
    else $error("holding register not loaded at byte end");
  chk_tx_no_rxflag: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && byte_done && !s_r.rd_dir) |=>
      (!$rose(s_r.receive_ready_flag) && !$rose(s_r.overrun_flag)))
    else $error("transmitted byte raised a receive flag");
  chk_stuck_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.stuck && s_r.st == TWM_IDLE) |=> (s_r.st == TWM_IDLE && s_r.stuck))
    else $error("locked master started a transfer");
  chk_start_cond: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_r.st == TWM_IDLE ##1 s_r.st == TWM_START) |-> (sda_oe && !scl_oe))
    else $error("start condition not made with clock released");

endmodule : twm_master

//--- twm_slave_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Behavioural two-wire slave; it changes its data line pull only on a falling clock edge or a start condition.
module twm_slave_model
#(
  parameter logic [6:0] SLV_ADDR = 7'h2a
)
(
  // Bus wires.
  input  wire logic       scl,
  input  wire logic       sda,
  // Test controls.
  input  wire logic       not_acknowledged_flag_data,
  input  wire logic [7:0] tx_byte,
  // Data line pull-down and the last written byte.
  output logic            sda_pull,
  output logic [7:0]      rx_byte
);
  logic [3:0] cnt;
  logic [1:0] nbyte;
  logic [7:0] sh;
  logic       sel;
  logic       rd;

  initial
  begin
    sda_pull = 1'b0;
    rx_byte  = 8'h00;
    sel      = 1'b0;
    rd       = 1'b0;
  end

  always @(negedge sda)
    if (scl)
    begin
      cnt      = 4'h0;
      nbyte    = 2'h0;
      sda_pull = 1'b0;
    end

  always @(posedge sda)
    if (scl)
      sel = 1'b0;

  always @(posedge scl)
  begin
    if (cnt < 4'h8)
      sh = {sh[6:0], sda};
    cnt = cnt + 4'h1;
  end

  always @(negedge scl)
    if (cnt == 4'h8)
    begin
      if (nbyte == 2'h0)
      begin
        sel = (sh[7:1] == SLV_ADDR);
        rd  = sh[0];
      end
      else if (!rd)
        rx_byte = sh;
      sda_pull = sel && (nbyte == 2'h0 || (!rd && !not_acknowledged_flag_data));
    end
    else if (cnt == 4'h9)
    begin
      cnt      = 4'h0;
      nbyte    = nbyte + 2'h1;
      sda_pull = sel && rd && nbyte == 2'h1 && !tx_byte[7];
    end
    else
      sda_pull = sel && rd && nbyte == 2'h1 && !tx_byte[3'd7 - cnt[2:0]];
endmodule : twm_slave_model

//--- tb_two_wire_master_behaviour.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: registers over AXI4-Lite, frames against the behavioural slave.
module tb_two_wire_master_behaviour;
  import twm_pkg::*;

  localparam logic [6:0] SLV_ADDR = 7'h2a;

  logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, scl, sda, scl_oe, sda_oe, sda_pull, not_acknowledged_flag_data;
  logic [7:0]  awaddr, araddr, tx_byte, rx_byte;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_fail, cmp_count;

  // Open-drain wires with pull-ups; no party stretches the clock.
  assign scl = !scl_oe;
  assign sda = !(sda_oe || sda_pull);

  twm_master i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe));

  twm_slave_model #(.SLV_ADDR(SLV_ADDR)) i_slave (.scl(scl), .sda(sda), .not_acknowledged_flag_data(not_acknowledged_flag_data),
    .tx_byte(tx_byte), .sda_pull(sda_pull), .rx_byte(rx_byte));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==========================================================================
  // Checking and closing.
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_resp

  function automatic logic [31:0] stat(input logic tc, rx, tx, nk, stk);
    stat                = 32'h0;
    stat[TWM_SR_TRANSFER_COMPLETE_FLAG] = tc;
    stat[TWM_SR_RECEIVE_READY_FLAG]  = rx;
    stat[TWM_SR_TRANSMIT_READY_FLAG]  = tx;
    stat[TWM_SR_NOT_ACKNOWLEDGED_FLAG]   = nk;
    stat[TWM_SR_STUCK]  = stk;
  endfunction : stat

  // ==========================================================================
  // Bus and link tasks.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic start_frame(input logic dir, input logic [6:0] a, input logic [7:0] b,
                             input logic [7:0] lo, input logic [7:0] hi, input logic [2:0] ex);
    logic [1:0] r;
    wr(TWM_CLKDIV_OFF, {13'h0, ex, hi, lo}, r);
    wr(TWM_MODE_OFF, {9'h0, a, 3'h0, dir, 12'h0}, r);
    wr(TWM_THR_OFF, {24'h0, b}, r);
    wr(TWM_CTRL_OFF, 32'h5, r);
  endtask : start_frame

  // Returns three clocks after the stop has been seen on the wires.
  task automatic wait_stop();
    logic p;
    do
    begin
      p = sda_oe;
      @(posedge aclk);
    end
    while (!(p && !sda_oe && !scl_oe));
    repeat (3) @(posedge aclk);
  endtask : wait_stop

  task automatic scl_rises(input int k);
    logic p;
    repeat (k)
      do
      begin
        p = scl_oe;
        @(posedge aclk);
      end
      while (!(p && !scl_oe));
  endtask : scl_rises

  task automatic count_phase(input logic lvl, input int exp);
    int n;
    n = 0;
    while (scl_oe == lvl)
    begin
      @(posedge aclk);
      n++;
    end
    cmp_val(32'(n), 32'(exp));
  endtask : count_phase

  task automatic hold_pins(input logic [1:0] v);
    repeat (4)
    begin
      repeat (25) @(posedge aclk);
      cmp_val({30'h0, scl_oe, sda_oe}, {30'h0, v});
    end
  endtask : hold_pins

  initial
  begin
    #240000;
    n_fail++;
    test_done();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  b;
    aresetn = 1'b0;
    ce      = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, not_acknowledged_flag_data} = 6'h0;
    {awaddr, araddr, tx_byte, wdata} = 56'h0;
    wstrb     = 4'hf;
    n_fail    = 0;
    cmp_count = 0;
    void'($urandom(15327));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    rd(8'h08, d, r);
    cmp_resp(r, TWM_RESP_SLVERR);
    wr(8'h0c, 32'h1, r);
    cmp_resp(r, TWM_RESP_SLVERR);
    b = 8'($urandom);
    tx_byte <= b;
    start_frame(1'b1, SLV_ADDR, 8'h00, 8'h08, 8'h08, 3'h0);
    while (!scl_oe)
      @(posedge aclk);
    count_phase(1'b1, 10);
    count_phase(1'b0, 10);
    wait_stop();
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    rd(TWM_RHR_OFF, d, r);
    cmp_val(d, {24'h0, b});
    start_frame(1'b1, SLV_ADDR, 8'h00, 8'(1 + $urandom % 15), 8'h03, 3'($urandom % 3));
    wait_stop();
    b = 8'($urandom);
    start_frame(1'b0, SLV_ADDR, b, 8'h08, 8'h08, 3'h0);
    wait_stop();
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    rd(TWM_RHR_OFF, d, r);
    cmp_val(d, {24'h0, b});
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($urandom);
      not_acknowledged_flag_data <= (k == 1);
      start_frame(1'b0, (k == 2) ? ~SLV_ADDR : SLV_ADDR, b, 8'(1 + $urandom % 15),
                  8'(1 + $urandom % 15), 3'($urandom % 3));
      wait_stop();
      rd(TWM_STAT_OFF, d, r);
      cmp_val(d, stat(1'b1, 1'b0, k != 2, k != 0, 1'b0));
      rd(TWM_STAT_OFF, d, r);
      cmp_val(d, stat(1'b1, 1'b0, k != 2, 1'b0, 1'b0));
      if (k == 0)
        cmp_val({24'h0, rx_byte}, {24'h0, b});
    end
    not_acknowledged_flag_data <= 1'b1;
    start_frame(1'b0, SLV_ADDR, 8'h3c, 8'h08, 8'h08, 3'h0);
    scl_rises(18);
    wait (scl_oe);
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    wait_stop();
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
    not_acknowledged_flag_data <= 1'b0;
    b = 8'($urandom);
    start_frame(1'b0, SLV_ADDR, b, 8'h08, 8'h08, 3'h0);
    scl_rises(5);
    wr(TWM_CTRL_OFF, 32'h8, r);
    hold_pins({scl_oe, sda_oe});
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(TWM_CTRL_OFF, 32'h4, r);
    wait_stop();
    cmp_val({24'h0, rx_byte}, {24'h0, b});
    start_frame(1'b0, SLV_ADDR, 8'h5a, 8'h08, 8'h08, 3'h0);
    scl_rises(2);
    wait (scl_oe);
    wr(TWM_CTRL_OFF, 32'h80, r);
    rd(TWM_STAT_OFF, d, r);
    cmp_val(d, stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
    wr(TWM_CTRL_OFF, 32'h5, r);
    hold_pins(2'b00);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(TWM_CTRL_OFF, 32'h4, r);
    start_frame(1'b0, SLV_ADDR, 8'hc3, 8'h08, 8'h08, 3'h0);
    wait_stop();
    cmp_val({24'h0, rx_byte}, 32'hc3);
    test_done();
  end
endmodule : tb_two_wire_master_behaviour
